/* core/vmc_defs.vh */
/*
  Constants for the voice message record/play sequencer.
  Assumes inclusion by bare name from the core modules.
*/
`ifndef VMC_DEFS_VH
`define VMC_DEFS_VH

// Clock rate in kHz (250 MHz)
`define VMC_CLK_KHZ        250000
// End-of-message pulse width in microseconds (10-second variant)
`define VMC_EOM_PULSE_US   15625
// Cycles of the end-of-message pulse, at 250 cycles per microsecond (exact product)
`define VMC_EOM_PULSE_CYC  ((`VMC_EOM_PULSE_US * 250) )
// Default sample period in clock cycles
`define VMC_SAMPLE_CYC     39063
// Default memory depth in samples
`define VMC_MEM_DEPTH      64000
// Address width
`define VMC_ADDR_W         16
// Zero address
`define VMC_ADDR_ZERO      16'h0000

`endif

/* core/vmc_sync.v */
/*
  Two-flop synchroniser with falling edge detect on the second stage.
  Assumes an asynchronous pin input and a clock enable shared with the core.
*/
`timescale 1ns/1ps
module vmc_sync (
  // Clock, reset, enable
  input  wire clk_sys_i,
  input  wire nrst_i,
  input  wire ce_i,
  // Pin side
  input  wire pin_i,
  // Synchronised outputs
  output reg  level_o,
  output wire fall_o
);
  reg meta;
  reg prev;

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta    <= 1'b1;
      level_o <= 1'b1;
      prev    <= 1'b1;
    end else if (ce_i) begin
      meta    <= pin_i;
      level_o <= meta;
      prev    <= level_o;
    end
  end

  assign fall_o = prev & ~level_o;
endmodule

/* core/vmc_core.v */
/*
  Voice message record/play control sequencer: address counter, marker
  storage, record indicator with end-of-message pulse.
  Assumes active-low control pins from buttons or a host, asynchronous
  to clk_sys_i; the audio path follows the mode and address outputs.
*/
// Overview of operation
// R01 - Record request going low starts recording at memory address zero.
// R02 - Held record request records until memory is full, then stops.
// R03 - Full recording stores marker at last address; power down on release.
// R04 - Edge play input falling starts playback at zero; rising edge ignored.
// R05 - A full-memory recording plays back the entire memory.
// R06 - Playback stops at the marker and powers down on its own.
// R07 - Later falling edges on edge play start fresh playback from zero.
// R08 - Level play input low starts playback at address zero.
// R09 - Level play input released high stops playback at once, powers down.
// R10 - Later falling edge on level play starts new playback from zero.
// R11 - Record falling edge overrides everything, restarting recording at zero.
// R12 - Early record release writes marker at that point and powers down.
// R13 - Record indicator is low while recording is in progress.
// R14 - Indicator returns high on record release or memory full.
// R15 - Reaching marker in playback pulses indicator low for fixed width.
// R16 - Address resets at cycle start, steps per sample, playback stops at end.
`timescale 1ns/1ps
`include "vmc_defs.vh"
module vmc_core #(
  parameter ADDR_W     = `VMC_ADDR_W,
  parameter MEM_DEPTH  = `VMC_MEM_DEPTH,
  parameter SAMPLE_CYC = `VMC_SAMPLE_CYC,
  parameter EOM_CYC    = `VMC_EOM_PULSE_CYC
) (
  // Clock, reset, enable
  input  wire              clk_sys_i,
  input  wire              nrst_i,
  input  wire              ce_i,
  // Control pins, active low
  input  wire              record_request_n_i,
  input  wire              play_edge_request_n_i,
  input  wire              play_level_request_n_i,
  // Indicator
  output reg               record_indicator_n_o,
  // Audio path control
  output reg               recording_o,
  output reg               playing_o,
  output reg               powered_down_o,
  output reg  [ADDR_W-1:0] address_o,
  output reg               sample_strobe_o
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_REC  = 4'b0010;
  localparam [3:0] ST_FULL = 4'b0100;
  localparam [3:0] ST_PLAY = 4'b1000;
  localparam [31:0]       LAST_FULL = MEM_DEPTH - 1;
  localparam [ADDR_W-1:0] LAST_ADDR = LAST_FULL[ADDR_W-1:0];
  localparam [31:0] SAMPLE_LAST = SAMPLE_CYC - 1;
  localparam [31:0] EOM_LAST    = EOM_CYC - 1;

  wire rec_lvl;
  wire rec_fall;
  wire pe_fall;
  wire pl_lvl;
  wire pl_fall;

  vmc_sync u_sync_rec (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (record_request_n_i),
    .level_o   (rec_lvl),
    .fall_o    (rec_fall)
  );

  vmc_sync u_sync_pe (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (play_edge_request_n_i),
    .level_o   (),
    .fall_o    (pe_fall)
  );

  vmc_sync u_sync_pl (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (play_level_request_n_i),
    .level_o   (pl_lvl),
    .fall_o    (pl_fall)
  );

  reg [3:0]        state;
  reg [31:0]       tick_cnt;
  reg [31:0]       eom_cnt;
  reg              eom_pulse;
  reg              level_mode;
  reg              marker_valid;
  reg [ADDR_W-1:0] marker_addr;

  reg [3:0]        next_state;
  reg [ADDR_W-1:0] next_address;
  reg              next_level_mode;
  reg              start_cycle;
  reg              write_marker;
  reg              hit_end;

  wire tick     = (tick_cnt == SAMPLE_LAST);
  wire at_last  = (address_o == LAST_ADDR);
  wire at_mark  = marker_valid && (address_o == marker_addr);

  always @* begin
    next_state      = state;
    next_address    = address_o;
    next_level_mode = level_mode;
    start_cycle     = 1'b0;
    write_marker    = 1'b0;
    hit_end         = 1'b0;
    if (rec_fall) begin
      next_state   = ST_REC;                         // see R11
      next_address = `VMC_ADDR_ZERO;                 // see R01
      start_cycle  = 1'b1;
    end else begin
      case (state)
        ST_REC: begin
          if (rec_lvl) begin
            next_state   = ST_IDLE;                  // see R12
            write_marker = 1'b1;
          end else if (tick && at_last) begin
            next_state   = ST_FULL;                  // see R02
            write_marker = 1'b1;                     // see R03
          end else if (tick) begin
            next_address = address_o + 1'b1;         // see R16
          end
        end
        ST_FULL: begin
          if (rec_lvl) begin
            next_state = ST_IDLE;                    // see R03
          end
        end
        ST_PLAY: begin
          if (pe_fall) begin
            next_address    = `VMC_ADDR_ZERO;        // see R07
            next_level_mode = 1'b0;
            start_cycle     = 1'b1;
          end else if (pl_fall) begin
            next_address    = `VMC_ADDR_ZERO;        // see R10
            next_level_mode = 1'b1;
            start_cycle     = 1'b1;
          end else if (level_mode && pl_lvl) begin
            next_state = ST_IDLE;                    // see R09
          end else if (tick && (at_mark || at_last)) begin
            next_state = ST_IDLE;                    // see R06
            hit_end    = 1'b1;                       // see R05
          end else if (tick) begin
            next_address = address_o + 1'b1;         // see R16
          end
        end
        default: begin
          if (pe_fall) begin
            next_state      = ST_PLAY;               // see R04
            next_address    = `VMC_ADDR_ZERO;
            next_level_mode = 1'b0;
            start_cycle     = 1'b1;
          end else if (pl_fall) begin
            next_state      = ST_PLAY;               // see R08
            next_address    = `VMC_ADDR_ZERO;
            next_level_mode = 1'b1;
            start_cycle     = 1'b1;
          end
        end
      endcase
    end
  end

  // Next values of timers and output flops
  reg [31:0]       next_tick_cnt;
  reg [31:0]       next_eom_cnt;
  reg              next_eom_pulse;
  reg              next_indicator_n;
  reg              next_strobe;
  reg              next_recording;
  reg              next_playing;
  reg              next_powered_down;

  // Sample timer restarts with each cycle
  always @* begin
    if (start_cycle || tick) begin
      next_tick_cnt = 32'h0000_0000;
    end else begin
      next_tick_cnt = tick_cnt + 32'h0000_0001;
    end
  end

  // End-of-message pulse; a new cycle cuts it short
  always @* begin
    next_eom_pulse = eom_pulse;
    next_eom_cnt   = eom_cnt;
    if (hit_end) begin
      next_eom_pulse = 1'b1;                         // see R15
      next_eom_cnt   = 32'h0000_0000;
    end else if (start_cycle) begin
      next_eom_pulse = 1'b0;
    end else if (eom_pulse) begin
      if (eom_cnt == EOM_LAST) begin
        next_eom_pulse = 1'b0;
      end else begin
        next_eom_cnt = eom_cnt + 32'h0000_0001;
      end
    end
  end

  // Indicator low while recording or during the end pulse
  always @* begin
    next_indicator_n = 1'b1;                         // see R14
    if (next_state == ST_REC) begin
      next_indicator_n = 1'b0;                       // see R13
    end else if (hit_end) begin
      next_indicator_n = 1'b0;                       // see R15
    end else if (eom_pulse && !start_cycle && (eom_cnt != EOM_LAST)) begin
      next_indicator_n = 1'b0;
    end
  end

  // Strobe marks the end of each sample period while active
  always @* begin
    next_strobe = 1'b0;
    if (tick && ((state == ST_REC) || (state == ST_PLAY))) begin
      next_strobe = 1'b1;                            // see R16
    end
  end

  // Mode flags follow the state being entered
  always @* begin
    next_recording    = (next_state == ST_REC);
    next_playing      = (next_state == ST_PLAY);
    next_powered_down = (next_state == ST_IDLE);
  end

  // Sequencer state and memory address
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state      <= ST_IDLE;
      address_o  <= `VMC_ADDR_ZERO;
      level_mode <= 1'b0;
    end else if (ce_i) begin
      state      <= next_state;
      address_o  <= next_address;
      level_mode <= next_level_mode;
    end
  end

  // Sample period timer
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt <= 32'h0000_0000;
    end else if (ce_i) begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // Marker store; a new recording discards the old marker
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      marker_valid <= 1'b0;
      marker_addr  <= `VMC_ADDR_ZERO;
    end else if (ce_i) begin
      if (start_cycle && next_state == ST_REC) begin
        marker_valid <= 1'b0;                        // see R11
      end else if (write_marker) begin
        marker_valid <= 1'b1;                        // see R12
        marker_addr  <= address_o;
      end
    end
  end

  // End pulse timer
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eom_pulse <= 1'b0;
      eom_cnt   <= 32'h0000_0000;
    end else if (ce_i) begin
      eom_pulse <= next_eom_pulse;
      eom_cnt   <= next_eom_cnt;
    end
  end

  // Output flops
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      record_indicator_n_o <= 1'b1;
      recording_o          <= 1'b0;
      playing_o            <= 1'b0;
      powered_down_o       <= 1'b1;
      sample_strobe_o      <= 1'b0;
    end else if (ce_i) begin
      record_indicator_n_o <= next_indicator_n;
      recording_o          <= next_recording;
      playing_o            <= next_playing;
      powered_down_o       <= next_powered_down;
      sample_strobe_o      <= next_strobe;
    end
  end
endmodule

/* test/vmc_core_assertions.sv */
/* Port checker for vmc_core.
   Assumes bind into vmc_core and shortened counts (EOM_CYC 5). */
`timescale 1ns/1ps
module vmc_core_assertions #(
  parameter ADDR_W    = 16,
  parameter MEM_DEPTH = 8
) (
  // Clock and reset
  input wire              clk_sys_i,
  input wire              nrst_i,
  // Pins
  input wire              record_request_n_i,
  // Outputs
  input wire              record_indicator_n_o,
  input wire              recording_o,
  input wire              playing_o,
  input wire              powered_down_o,
  input wire [ADDR_W-1:0] address_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_held_high; record_request_n_i [*5]; endsequence
  sequence s_eom_low; !record_indicator_n_o [*5] ##1 record_indicator_n_o; endsequence
  property p_led_rec; recording_o |-> !record_indicator_n_o; endproperty
  property p_rec_go; $fell(record_request_n_i) |-> ##[3:6] (recording_o && address_o == 0);
  endproperty
  property p_rec_stop; $rose(record_request_n_i) ##1 s_held_high
    |-> !recording_o && record_indicator_n_o; endproperty
  property p_rec_zero; $rose(recording_o) |-> address_o == 0 && !powered_down_o; endproperty
  property p_play_zero; $rose(playing_o) |-> address_o == 0; endproperty
  property p_excl; !(recording_o && playing_o); endproperty
  property p_idle; powered_down_o |-> !recording_o && !playing_o; endproperty
  property p_addr; $changed(address_o) |-> address_o == 0 || address_o == $past(address_o) + 1;
  endproperty
  property p_max; address_o < MEM_DEPTH; endproperty
  property p_eom; $fell(playing_o) && !record_indicator_n_o && !recording_o |-> s_eom_low;
  endproperty
  a_led_rec: assert property (p_led_rec) else $error("indicator high in record");
  a_rec_go: assert property (p_rec_go) else $error("record did not start");
  a_rec_stop: assert property (p_rec_stop) else $error("record did not stop");
  a_rec_zero: assert property (p_rec_zero) else $error("record not at zero");
  a_play_zero: assert property (p_play_zero) else $error("play not at zero");
  a_excl: assert property (p_excl) else $error("record and play together");
  a_idle: assert property (p_idle) else $error("active while powered down");
  a_addr: assert property (p_addr) else $error("address skipped");
  a_max: assert property (p_max) else $error("address past end");
  a_eom: assert property (p_eom) else $error("bad end pulse width");
endmodule
bind vmc_core vmc_core_assertions #(.ADDR_W(ADDR_W), .MEM_DEPTH(MEM_DEPTH)) vmc_core_assertions_i (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .record_request_n_i(record_request_n_i),
  .record_indicator_n_o(record_indicator_n_o), .recording_o(recording_o),
  .playing_o(playing_o), .powered_down_o(powered_down_o), .address_o(address_o));

/* test/vmc_button_model.sv */
/* Button model for the three active-low control pins.
   Assumes pulled-up pins, changed just after a clock edge. */
`timescale 1ns/1ps
module vmc_button_model (
  // Clock
  input  wire clk_sys_i,
  // Pins, active low
  output reg  record_request_n_o = 1'b1,
  output reg  play_edge_request_n_o = 1'b1,
  output reg  play_level_request_n_o = 1'b1
);
  // Pin 0 record, 1 edge play, 2 level play
  task drive(input int sel, input logic lvl);
    @(posedge clk_sys_i);
    case (sel)
      0: record_request_n_o <= lvl;
      1: play_edge_request_n_o <= lvl;
      default: play_level_request_n_o <= lvl;
    endcase
  endtask
endmodule

/* test/tb_vmc_core.sv */
/* Self-checking bench for vmc_core.
   Assumes shortened counts: 4-cycle sample, 8-deep memory. */
`timescale 1ns/1ps
module tb_vmc_core;
  localparam int SAMP = 4;
  localparam int DEPTH = 8;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        ce_i = 1'b1;
  wire         rec_n, pe_n, pl_n, led_n, rec_o, play_o, pd_o, strobe_o;
  wire  [15:0] addr_o;
  logic [15:0] last_rec, last_play;
  int          bad_count = 0;
  int          samples_checked = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (rec_o) last_rec <= addr_o;
    if (play_o) last_play <= addr_o;
  end
  vmc_button_model vmc_button_model_i (.clk_sys_i(clk_sys_i), .record_request_n_o(rec_n),
    .play_edge_request_n_o(pe_n), .play_level_request_n_o(pl_n));
  vmc_core #(.ADDR_W(16), .MEM_DEPTH(DEPTH), .SAMPLE_CYC(SAMP), .EOM_CYC(5)) vmc_core_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i), .record_request_n_i(rec_n),
    .play_edge_request_n_i(pe_n), .play_level_request_n_i(pl_n),
    .record_indicator_n_o(led_n), .recording_o(rec_o), .playing_o(play_o),
    .powered_down_o(pd_o), .address_o(addr_o), .sample_strobe_o(strobe_o));
  task check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task pin(input int s, input logic v);
    vmc_button_model_i.drive(s, v);
  endtask
  task idle_wait();
    int k;
    k = 0;
    while (pd_o !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
  endtask
  task t_rec_full();
    pin(0, 0); cyc(6);
    check(rec_o, 1);
    check(addr_o, 0);
    check(led_n, 0);
    cyc(1);
    check(strobe_o, 1);
    cyc(1);
    check(strobe_o, 0);
    cyc(DEPTH * SAMP + 4);
    check(rec_o, 0);
    check(addr_o, DEPTH - 1);
    check(led_n, 1);
    check(pd_o, 0);
    pin(0, 1); cyc(7);
    check(pd_o, 1);
    check(led_n, 1);
    $display("done rec_full");
  endtask
  task t_play_edge();
    pin(1, 0); cyc(6);
    check(play_o, 1);
    pin(1, 1); cyc(6);
    check(play_o, 1);
    idle_wait();
    check(last_play, DEPTH - 1);
    check(led_n, 0);
    cyc(4);
    check(led_n, 0);
    cyc(1);
    check(led_n, 1);
    pin(1, 0); cyc(6);
    check({play_o, addr_o[14:0]}, 16'h8000);
    pin(1, 1); cyc(2); idle_wait(); cyc(8);
    $display("done play_edge");
  endtask
  task t_play_level();
    pin(2, 0); cyc(6);
    check({play_o, addr_o[14:0]}, 16'h8000);
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    cyc(3 * SAMP);
    check({play_o, addr_o[14:0]}, 16'h8001);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    cyc(2 * SAMP);
    pin(2, 1); cyc(6);
    check({play_o, pd_o}, 16'h0001);
    pin(2, 0); cyc(6);
    check({play_o, addr_o[14:0]}, 16'h8000);
    idle_wait();
    check(last_play, DEPTH - 1);
    pin(2, 1); cyc(10);
    $display("done play_level");
  endtask
  task t_rec_abort();
    pin(1, 0); cyc(6 + SAMP);
    pin(0, 0); cyc(6);
    check({rec_o, play_o, addr_o[13:0]}, 16'h8000);
    cyc(2 * SAMP);
    pin(0, 1); pin(1, 1); cyc(7);
    check(pd_o, 1);
    pin(1, 0); cyc(6); idle_wait();
    check(last_play, last_rec);
    pin(1, 1); cyc(10);
    $display("done rec_abort");
  endtask
  task tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cyc(2);
    nrst_i <= 1'b1;
    cyc(1);
    t_rec_full(); t_play_edge(); t_play_level(); t_rec_abort();
    tally_and_finish();
  end
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
endmodule
